// ### spc_defs.svh
// offsets, field positions, reset values and timing counts of the sleep and prescale controller
// Contract
// - divider select codes 0 to 8 divide the system clock by two to the code
// - reset loads divider select 0000, or 0011 when the divide-by-eight fuse is programmed
// - software may write any divider select value at run time
// - the divided clock paces the core and every synchronous peripheral
// - sleep happens only with sleep_arm_bit set when the sleep instruction runs
// - mode 000 idle stops only core and program memory clocks
// - mode 001 stops io, core and program memory clocks; converter and async run
// - mode 010 power-down stops the oscillator and all generated clocks
// - mode 011 power-save is power-down plus a running async timer that may wake
// - modes 110 and 111 keep the oscillator and wake in six cycles; 100, 101 reserved
// - an enabled interrupt wakes the device and holds the core four extra cycles
// - waking leaves register file and memory contents untouched
// - a reset during sleep wakes the device and restarts from the reset vector
// - converter quiet mode wakes only on its listed sources
// - power-down wakes only on its listed sources
// - outside idle the two external interrupts wake only when level sensed
// - entering idle or converter quiet mode starts a conversion if the converter is on
// - brownout_sleep_off turns the detector off in deep modes and back on at wake
// - after sleep with the detector off wake-up lasts about 60 us
// - bit 6 of processor_control_register is brownout_sleep_off, reset zero
// - brownout_sleep_off changes only inside a timed sequence opened by its enable bit
// - waking from power-down waits the start-up delay chosen by clock_source_fuse
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// register byte offsets
`define SPC_OFS_DIV 4'h0
`define SPC_OFS_SLEEP 4'h4
`define SPC_OFS_PROC 4'h8
`define SPC_OFS_STAT 4'hc

// divider select field
`define SPC_DIVSEL_NOFUSE 4'h0
`define SPC_DIVSEL_FUSE 4'h3
`define SPC_DIVSEL_MAX 4'h8

// field positions
`define SPC_SE_BIT 0
`define SPC_SM_LSB 1
`define SPC_BODSE_BIT 5
`define SPC_BROWNOUT_SLEEP_OFF_BIT 6

// sleep mode codes
`define SPC_SM_IDLE 3'h0
`define SPC_SM_ADCNR 3'h1
`define SPC_SM_PDOWN 3'h2
`define SPC_SM_PSAVE 3'h3
`define SPC_SM_STBY 3'h6
`define SPC_SM_XSTBY 3'h7

// timing
`define SPC_CLK_MHZ 50
`define SPC_TIMED_WIN 3'h4
`define SPC_HALT_CYC 16'h0004
`define SPC_STBY_CYC 16'h0006
`define SPC_EXTCLK_FUSE 4'h0
`define SPC_BOD_WAKE_NS 60000
`define SPC_BOD_WAKE_CYC ((`SPC_BOD_WAKE_NS * `SPC_CLK_MHZ + 999) / 1000)

`endif

// ### spc_pkg.sv
// types shared by the sleep and prescale controller
package spc_pkg;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} spc_state_e;

  // clock domain, oscillator and detector enables, one bit each
  typedef struct packed {
    logic core;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic main_osc;
    logic timer_osc;
    logic brownout_detector;
  } spc_gate_s;

  // divided clock enables for the synchronous domains
  typedef struct packed {
    logic core;
    logic flash;
    logic io;
    logic adc;
  } spc_clken_s;

  // pending wake requests from the interrupt sources
  typedef struct packed {
    logic adc_done;
    logic wdt;
    logic twi_match;
    logic async_timer;
    logic store_ready;
    logic ext_irq_zero;
    logic ext_irq_one;
    logic pin_change;
    logic other;
  } spc_wake_s;

endpackage

// ### spc_clk_div.sv
// glitch-free power-of-two system clock enable divider
`timescale 1ns/10ps
`include "spc_defs.svh"
module spc_clk_div #(
  parameter int SEL_W = 4,
  parameter int CNT_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [SEL_W-1:0] sel_in,
  output logic tick_out,
  output logic [SEL_W-1:0] sel_applied_out
);

  logic [CNT_W-1:0] cnt;
  logic [SEL_W-1:0] sel_q;
  logic tick_q;
  wire [SEL_W-1:0] sel_clamp;
  wire [CNT_W-1:0] mask;
  wire hit;

  // reserved codes run at the slowest rate
  assign sel_clamp = (sel_in > `SPC_DIVSEL_MAX) ? `SPC_DIVSEL_MAX : sel_in;
  assign mask = CNT_W'((1 << sel_q) - 1);
  assign hit = (cnt & mask) == mask;
  assign tick_out = tick_q;
  assign sel_applied_out = sel_q;

  // new setting is taken only at a period boundary, so no short pulse
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt <= {CNT_W{1'b1}};
      sel_q <= `SPC_DIVSEL_MAX;
      tick_q <= 1'b0;
    end else begin
      cnt <= cnt + 1'b1;
      tick_q <= hit;
      if (hit) begin
        sel_q <= sel_clamp;
      end
    end
  end

  property p_div_two;
    @(posedge clk_in) disable iff (rst_in)
      (tick_q && sel_q == 4'h1 && $stable(sel_q)) |=> !tick_q ##1 tick_q;
  endproperty
  a_div_two: assert property (p_div_two) else $error("divide by two tick spacing wrong");

endmodule

// ### spc_wake_timer.sv
// down counter that times the wake-up hold of the core
`timescale 1ns/10ps
module spc_wake_timer #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [W-1:0] count_in,
  output logic done_out,
  output logic busy_out
);

  logic [W-1:0] cnt;

  // done marks the last cycle of the loaded count
  assign done_out = (cnt == W'(1));
  assign busy_out = (cnt != '0);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt <= '0;
    end else if (load_in) begin
      cnt <= count_in;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

endmodule

// ### spc_ctrl.sv
// sleep mode sequencer, clock gating and system clock prescaler with avalon registers
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "spc_defs.svh"
module spc_ctrl import spc_pkg::*; #(
  parameter logic [15:0] STARTUP_CYCLES = 16'd1024
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic div_by_eight_fuse_in,
  input wire logic [3:0] clock_source_fuse_in,
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  input wire logic sleep_instr_in,
  input wire logic adc_enabled_in,
  input wire logic async_timer_active_in,
  input wire logic [1:0] ext_irq_level_sense_in,
  input wire spc_wake_s wake_in,
  input wire logic reset_wake_in,
  output spc_gate_s gate_out,
  output spc_clken_s clk_en_out,
  output logic adc_start_out,
  output logic resume_out,
  output logic restart_vector_out,
  output logic sleeping_out
);

  // ****************************************
  // functions
  // ****************************************

  // clock domains left running in each sleep mode
  function automatic spc_gate_s mode_gates(input logic [2:0] mode, input logic asy_on);
    spc_gate_s g;
    g = '0;
    g.brownout_detector = 1'b1;
    unique case (mode)
      `SPC_SM_IDLE: begin
        g.io = 1'b1;
        g.adc = 1'b1;
        g.asy = 1'b1;
        g.main_osc = 1'b1;
        g.timer_osc = asy_on;
      end
      `SPC_SM_ADCNR: begin
        g.adc = 1'b1;
        g.asy = 1'b1;
        g.main_osc = 1'b1;
        g.timer_osc = asy_on;
      end
      `SPC_SM_PDOWN: begin
        g.brownout_detector = 1'b1;
      end
      `SPC_SM_PSAVE: begin
        g.asy = asy_on;
        g.timer_osc = asy_on;
      end
      `SPC_SM_STBY: begin
        g.main_osc = 1'b1;
      end
      `SPC_SM_XSTBY: begin
        g.asy = asy_on;
        g.main_osc = 1'b1;
        g.timer_osc = asy_on;
      end
      default: begin
        g = '1;
      end
    endcase
    return g;
  endfunction

  // wake sources honoured by each sleep mode
  function automatic logic wake_allowed(input logic [2:0] mode, input spc_wake_s w,
                                        input logic [1:0] lvl);
    logic idle;
    logic e0;
    logic e1;
    logic common;
    logic ok;
    idle = (mode == `SPC_SM_IDLE);
    e0 = w.ext_irq_zero & (idle | lvl[0]);
    e1 = w.ext_irq_one & (idle | lvl[1]);
    common = w.wdt | w.twi_match | e0 | e1 | w.pin_change;
    unique case (mode)
      `SPC_SM_IDLE: ok = |w;
      `SPC_SM_ADCNR: ok = common | w.adc_done | w.async_timer | w.store_ready;
      `SPC_SM_PDOWN: ok = common;
      `SPC_SM_PSAVE: ok = common | w.async_timer;
      `SPC_SM_STBY: ok = common;
      `SPC_SM_XSTBY: ok = common | w.async_timer;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // cycles that the core stays halted after a wake event
  function automatic logic [15:0] wake_cycles(input logic [2:0] mode, input logic [3:0] fuse,
                                              input logic bod_off, input logic [15:0] startup);
    logic [15:0] base;
    base = 16'h0000;
    if (mode == `SPC_SM_PDOWN || mode == `SPC_SM_PSAVE) begin
      base = (fuse == `SPC_EXTCLK_FUSE) ? `SPC_STBY_CYC : startup;
    end else if (mode == `SPC_SM_STBY || mode == `SPC_SM_XSTBY) begin
      base = `SPC_STBY_CYC;
    end
    if (bod_off && base < 16'(`SPC_BOD_WAKE_CYC)) begin
      base = 16'(`SPC_BOD_WAKE_CYC);
    end
    return base + `SPC_HALT_CYC;
  endfunction

  // ****************************************
  // registers and bus slave
  // ****************************************

  logic [3:0] divider_select;
  logic sleep_arm_bit;
  logic [2:0] sleep_mode_select;
  logic brownout_sleep_off;
  logic [2:0] timed_win;
  logic ack_q;
  logic [31:0] rdata_q;
  spc_state_e state;
  spc_state_e next_state;
  logic [2:0] mode_q;
  logic bod_off_q;
  spc_gate_s gate_q;
  spc_gate_s next_gate;
  spc_clken_s clk_en_q;
  logic adc_start_q;
  logic resume_q;
  logic restart_q;
  logic tick;
  logic [3:0] sel_applied;
  logic timer_done;

  wire req = read_in | write_in;
  wire wr_commit = write_in & ack_q & byteenable_in[0];
  wire wr_div = wr_commit & (address_in == `SPC_OFS_DIV);
  wire wr_sleep = wr_commit & (address_in == `SPC_OFS_SLEEP);
  wire wr_proc = wr_commit & (address_in == `SPC_OFS_PROC);
  wire brownout_sleep_off_open = writedata_in[`SPC_BROWNOUT_SLEEP_OFF_BIT] & writedata_in[`SPC_BODSE_BIT];
  wire brownout_sleep_off_take = (timed_win != 3'h0) & ~writedata_in[`SPC_BODSE_BIT];
  wire [7:0] div_rd = {4'h0, divider_select};
  wire [7:0] sleep_rd = {4'h0, sleep_mode_select, sleep_arm_bit};
  wire [7:0] proc_rd = {1'b0, brownout_sleep_off, 6'h00};
  wire [7:0] stat_rd = {sel_applied, 1'b0, bod_off_q, state == ST_WAKE, state == ST_SLEEP};
  wire [7:0] rd_mux = (address_in == `SPC_OFS_DIV) ? div_rd :
                      (address_in == `SPC_OFS_SLEEP) ? sleep_rd :
                      (address_in == `SPC_OFS_PROC) ? proc_rd :
                      (address_in == `SPC_OFS_STAT) ? stat_rd : 8'h00;

  // one wait cycle, then the answer; unmapped reads give zero
  assign waitrequest_out = req & ~ack_q;
  assign readdata_out = rdata_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (read_in & ~ack_q) begin
        rdata_q <= {24'h00_0000, rd_mux};
      end
    end
  end

  // divider select and sleep control
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      divider_select <= div_by_eight_fuse_in ? `SPC_DIVSEL_FUSE : `SPC_DIVSEL_NOFUSE;
      sleep_arm_bit <= 1'b0;
      sleep_mode_select <= `SPC_SM_IDLE;
    end else begin
      if (wr_div) begin
        divider_select <= writedata_in[3:0];
      end
      if (wr_sleep) begin
        sleep_arm_bit <= writedata_in[`SPC_SE_BIT];
        sleep_mode_select <= writedata_in[`SPC_SM_LSB +: 3];
      end
    end
  end

  // brownout_sleep_off behind the timed enable window
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      brownout_sleep_off <= 1'b0;
      timed_win <= 3'h0;
    end else if (wr_proc && brownout_sleep_off_open) begin
      timed_win <= `SPC_TIMED_WIN;
    end else begin
      if (wr_proc && brownout_sleep_off_take) begin
        brownout_sleep_off <= writedata_in[`SPC_BROWNOUT_SLEEP_OFF_BIT];
      end
      if (timed_win != 3'h0) begin
        timed_win <= timed_win - 3'h1;
      end
    end
  end

  // ****************************************
  // prescaler and wake timer
  // ****************************************

  spc_clk_div #(.SEL_W(4), .CNT_W(8)) u_div (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .sel_in(divider_select),
    .tick_out(tick),
    .sel_applied_out(sel_applied)
  );

  wire arm_ok = sleep_instr_in & sleep_arm_bit;
  wire mode_ok = sleep_mode_select[2:1] != 2'b10;
  wire enter = (state == ST_RUN) & arm_ok & mode_ok;
  wire deep = sleep_mode_select[1];
  wire wake_ok = wake_allowed(mode_q, wake_in, ext_irq_level_sense_in);
  wire go_wake = (state == ST_SLEEP) & wake_ok & ~reset_wake_in;
  wire [15:0] hold = wake_cycles(mode_q, clock_source_fuse_in, bod_off_q, STARTUP_CYCLES);

  spc_wake_timer #(.W(16)) u_wake (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .load_in(go_wake),
    .count_in(hold),
    .done_out(timer_done),
    .busy_out()
  );

  // ****************************************
  // sleep sequencer
  // ****************************************

  // next state; a reset request returns sleep and wake to run
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (enter) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (reset_wake_in) begin
          next_state = ST_RUN;
        end else if (wake_ok) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (reset_wake_in || timer_done) begin
          next_state = ST_RUN;
        end
      end
    endcase
  end

  // gates for the coming cycle; wake restarts oscillator and detector
  always_comb begin
    next_gate = '1;
    if (next_state == ST_SLEEP) begin
      next_gate = mode_gates(enter ? sleep_mode_select : mode_q, async_timer_active_in);
      next_gate.brownout_detector = ~(enter ? (brownout_sleep_off & deep) : bod_off_q);
    end else if (next_state == ST_WAKE) begin
      next_gate = mode_gates(mode_q, async_timer_active_in);
      next_gate.main_osc = 1'b1;
      next_gate.brownout_detector = 1'b1;
    end
  end

  // state, latched mode and detector switch-off; nothing else is touched on wake
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_RUN;
      mode_q <= `SPC_SM_IDLE;
      bod_off_q <= 1'b0;
    end else begin
      state <= next_state;
      if (enter) begin
        mode_q <= sleep_mode_select;
        bod_off_q <= brownout_sleep_off & deep;
      end else if (next_state == ST_RUN) begin
        bod_off_q <= 1'b0;
      end
    end
  end

  // registered gates, divided enables and event pulses
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gate_q <= '1;
      clk_en_q <= '0;
      adc_start_q <= 1'b0;
      resume_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      gate_q <= next_gate;
      clk_en_q <= {tick & next_gate.core, tick & next_gate.flash,
                   tick & next_gate.io, tick & next_gate.adc};
      adc_start_q <= enter & adc_enabled_in & ~sleep_mode_select[1];
      resume_q <= (state == ST_WAKE) & timer_done & ~reset_wake_in;
      restart_q <= (state != ST_RUN) & reset_wake_in;
    end
  end

  assign gate_out = gate_q;
  assign clk_en_out = clk_en_q;
  assign adc_start_out = adc_start_q;
  assign resume_out = resume_q;
  assign restart_vector_out = restart_q;
  assign sleeping_out = (state != ST_RUN);

  // ****************************************
  // assertions
  // ****************************************

  wire edge_only0 = wake_in.ext_irq_zero & ~ext_irq_level_sense_in[0] &
                    ((wake_in & ~spc_wake_s'(9'h008)) == '0);

  property p_reset_div;
    @(posedge clk_in) rst_in |=> divider_select == ($past(div_by_eight_fuse_in) ? 4'h3 : 4'h0);
  endproperty
  a_reset_div: assert property (p_reset_div) else $error("divider reset value wrong");

  property p_noop;
    @(posedge clk_in) disable iff (rst_in)
      (state == ST_RUN && sleep_instr_in && !sleep_arm_bit) |=> state == ST_RUN && gate_q == '1;
  endproperty
  a_noop: assert property (p_noop) else $error("unarmed sleep changed clocks");

  property p_idle_gates;
    @(posedge clk_in) disable iff (rst_in)
      (enter && sleep_mode_select == 3'h0) |=> !gate_q.core && !gate_q.flash && gate_q.io
        && gate_q.adc && gate_q.main_osc;
  endproperty
  a_idle_gates: assert property (p_idle_gates) else $error("idle gating wrong");

  property p_adcnr_gates;
    @(posedge clk_in) disable iff (rst_in)
      (enter && sleep_mode_select == 3'h1) |=> !gate_q.io && !gate_q.core && gate_q.adc;
  endproperty
  a_adcnr_gates: assert property (p_adcnr_gates) else $error("quiet mode gating wrong");

  property p_pdown_gates;
    @(posedge clk_in) disable iff (rst_in)
      (enter && sleep_mode_select == 3'h2) |=> !gate_q.main_osc && !gate_q.io && !gate_q.asy;
  endproperty
  a_pdown_gates: assert property (p_pdown_gates) else $error("power-down gating wrong");

  sequence s_idle_hold;
    state == ST_WAKE [*4] ##1 state == ST_RUN && resume_q;
  endsequence

  property p_idle_wake;
    @(posedge clk_in) disable iff (rst_in)
      (go_wake && mode_q == 3'h0 && !bod_off_q) ##1 !reset_wake_in [*4] |-> ##1 resume_q;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake hold not four");

  property p_idle_seq;
    @(posedge clk_in) disable iff (rst_in || reset_wake_in)
      (go_wake && mode_q == 3'h0 && !bod_off_q) |=> s_idle_hold;
  endproperty
  a_idle_seq: assert property (p_idle_seq) else $error("idle wake sequence wrong");

  property p_edge_no_wake;
    @(posedge clk_in) disable iff (rst_in)
      (state == ST_SLEEP && mode_q != 3'h0 && edge_only0 && !reset_wake_in) |=> state == ST_SLEEP;
  endproperty
  a_edge_no_wake: assert property (p_edge_no_wake) else $error("edge irq woke device");

  property p_reset_wake;
    @(posedge clk_in) disable iff (rst_in)
      (state != ST_RUN && reset_wake_in) |=> state == ST_RUN && restart_vector_out && !resume_q;
  endproperty
  a_reset_wake: assert property (p_reset_wake) else $error("reset in sleep not honoured");

  property p_bod_off;
    @(posedge clk_in) disable iff (rst_in)
      (enter && brownout_sleep_off && sleep_mode_select == 3'h2) |=> !gate_q.brownout_detector ##1 bod_off_q;
  endproperty
  a_bod_off: assert property (p_bod_off) else $error("detector not switched off");

  property p_brownout_sleep_off_locked;
    @(posedge clk_in) disable iff (rst_in)
      (timed_win == 3'h0 && !(wr_proc && brownout_sleep_off_open)) |=> $stable(brownout_sleep_off);
  endproperty
  a_brownout_sleep_off_locked: assert property (p_brownout_sleep_off_locked) else $error("untimed write changed bit");

  property p_adc_start;
    @(posedge clk_in) disable iff (rst_in)
      (enter && adc_enabled_in && sleep_mode_select == 3'h1) |=> adc_start_out ##1 !adc_start_out;
  endproperty
  a_adc_start: assert property (p_adc_start) else $error("conversion not started");

endmodule

// ### spc_core_model.sv
// core side model that issues sleep instructions and holds wake requests
`timescale 1ns/10ps
module spc_core_model import spc_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire spc_wake_s raise_in,
  input wire logic resume_in,
  input wire logic restart_in,
  output logic sleep_instr_out,
  output spc_wake_s wake_out
);
  // one-cycle sleep instruction per request
  always_ff @(posedge clk_in) begin
    sleep_instr_out <= go_in & ~rst_in;
  end
  // pending requests stand as levels until serviced or restarted
  always_ff @(posedge clk_in) begin
    if (rst_in | resume_in | restart_in) begin
      wake_out <= '0;
    end else begin
      wake_out <= wake_out | raise_in;
    end
  end
endmodule

// ### tb_spc_ctrl.sv
// self-checking bench for the sleep and prescale controller
`timescale 1ns/10ps
`include "spc_defs.svh"
module tb_spc_ctrl import spc_pkg::*;;
  logic clk_in = 0, rst_in = 1, fuse = 1, rd = 0, wr = 0, go = 0, rstw = 0;
  logic [3:0] addr = 0;
  logic [3:0] csf = 4'h0;
  logic [31:0] wd = 0, rdata, q;
  logic [1:0] lvl = 2'b10;
  logic wreq, adcs, resume, rv, sleeping, instr;
  spc_wake_s raise = '0, wake;
  spc_gate_s gate;
  spc_clken_s clken;
  int failures = 0, compares = 0, ncyc = 0, nres = 0, nrv = 0, nadc = 0, ncore = 0;
  int tres, t0, r0, n, a0;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  logic [7:0] gexp [6] = '{8'h3f, 8'h1f, 8'h01, 8'h0b, 8'h05, 8'h0f};
  logic [8:0] src [6] = '{9'h001, 9'h100, 9'h002, 9'h004, 9'h040, 9'h080};
  logic [8:0] ign [6] = '{9'h000, 9'h009, 9'h139, 9'h008, 9'h000, 9'h000};
  int hexp [6] = '{5, 5, 11, 21, 11, 11};
  logic [3:0] codes [5] = '{4'hf, 4'h8, 4'h3, 4'h1, 4'h0};
  logic [3:0] noop [3] = '{4'h0, 4'h9, 4'hb};

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  spc_ctrl #(.STARTUP_CYCLES(16'd16)) u_spc_ctrl (.clk_in(clk_in), .rst_in(rst_in),
    .div_by_eight_fuse_in(fuse), .clock_source_fuse_in(csf), .address_in(addr),
    .read_in(rd), .write_in(wr), .writedata_in(wd), .byteenable_in(4'h1),
    .readdata_out(rdata), .waitrequest_out(wreq), .sleep_instr_in(instr),
    .adc_enabled_in(1'b1), .async_timer_active_in(1'b1), .ext_irq_level_sense_in(lvl),
    .wake_in(wake), .reset_wake_in(rstw), .gate_out(gate), .clk_en_out(clken),
    .adc_start_out(adcs), .resume_out(resume), .restart_vector_out(rv),
    .sleeping_out(sleeping));

  spc_core_model u_spc_core_model (.clk_in(clk_in), .rst_in(rst_in), .go_in(go),
    .raise_in(raise), .resume_in(resume), .restart_in(rv), .sleep_instr_out(instr),
    .wake_out(wake));

  // monitors sample between edges; cycle ceiling cuts a hang short
  always @(negedge clk_in) begin
    ncyc++;
    if (resume === 1'b1) begin
      nres++;
      tres = ncyc;
    end
    if (rv === 1'b1) nrv++;
    if (adcs === 1'b1) nadc++;
    if (clken.core === 1'b1) ncore++;
    if (ncyc == 20000) begin
      failures++;
      results();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // avalon access: hold request until waitrequest is seen low at an edge
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wd <= {24'h0, d};
    @(posedge clk_in);
    while (wreq !== 1'b0) @(posedge clk_in);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_in);
  endtask

  task enter(input logic [3:0] v);
    bus(1, `SPC_OFS_SLEEP, {4'h0, v});
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  // raise a wake source, return cycles from pending level to resume pulse
  task wake_up(input logic [8:0] s);
    raise <= s;
    @(posedge clk_in);
    raise <= '0;
    t0 = ncyc + 1;
    r0 = nres;
    while (nres == r0) @(posedge clk_in);
    n = tres - t0;
    @(posedge clk_in);
  endtask

  task results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    bus(0, `SPC_OFS_DIV, 0);
    chk("div fuse", 32'h3, q);
    bus(0, `SPC_OFS_PROC, 0);
    chk("proc reset", 32'h0, q);
    bus(0, 4'h2, 0);
    chk("unmapped", 32'h0, q);
    fuse <= 1'b0;
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    bus(0, `SPC_OFS_DIV, 0);
    chk("div nofuse", 32'h0, q);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      enter(noop[i]);
      chk("noop sleeping", 1'b0, sleeping);
      chk("noop gate", 8'hff, gate);
    end
    $display("test noop done");
    for (int i = 0; i < 6; i++) begin
      a0 = nadc;
      csf <= (i == 3) ? 4'h1 : 4'h0;
      enter({modes[i], 1'b1});
      chk("sleeping", 1'b1, sleeping);
      chk("gate", gexp[i], gate);
      chk("adc start", (modes[i] < 2), nadc - a0);
      if (ign[i] != 0) begin
        raise <= ign[i];
        @(posedge clk_in);
        raise <= '0;
        repeat (20) @(posedge clk_in);
        chk("ignored wake", 1'b1, sleeping);
      end
      wake_up(src[i]);
      chk("wake cycles", hexp[i], n);
      chk("gate after", 8'hff, gate);
    end
    bus(0, `SPC_OFS_SLEEP, 0);
    chk("sleep reg kept", 32'hf, q);
    $display("test modes done");
    enter(4'h5);
    r0 = nres;
    a0 = nrv;
    rstw <= 1'b1;
    @(posedge clk_in);
    rstw <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("restart", 1, nrv - a0);
    chk("no resume", r0, nres);
    chk("restart awake", 1'b0, sleeping);
    $display("test reset wake done");
    bus(1, `SPC_OFS_PROC, 8'h40);
    bus(0, `SPC_OFS_PROC, 0);
    chk("untimed write", 32'h0, q);
    bus(1, `SPC_OFS_PROC, 8'h60);
    bus(1, `SPC_OFS_PROC, 8'h40);
    bus(0, `SPC_OFS_PROC, 0);
    chk("timed write", 32'h40, q);
    enter(4'h5);
    chk("detector off", 8'h00, gate);
    bus(0, `SPC_OFS_STAT, 0);
    chk("status", 32'h5, q);
    a0 = ncore;
    wake_up(9'h002);
    chk("long wake", 1'b1, n > `SPC_BOD_WAKE_CYC && n <= `SPC_BOD_WAKE_CYC + 12);
    chk("detector on", 8'hff, gate);
    chk("core stopped", 32'h2, ncore - a0);
    $display("test detector done");
    for (int i = 0; i < 5; i++) begin
      bus(1, `SPC_OFS_DIV, {4'h0, codes[i]});
      bus(0, `SPC_OFS_DIV, 0);
      chk("div any", codes[i], q);
      repeat (600) @(posedge clk_in);
      a0 = ncore;
      repeat (512) @(posedge clk_in);
      chk("ticks", 512 >> ((codes[i] > 8) ? 8 : codes[i]), ncore - a0);
    end
    $display("test divider done");
    results();
  end
endmodule
